// >>> src/dsb_diag_builder.sv
// Purpose: Builds the diagnostic response of a fieldbus slave as a byte stream
// Assumes: One clock, APB register access, master acknowledges interrupts by pulse
// Notes: Response = standard, identifier, module status, optional interrupt block
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module dsb_diag_builder #(
  parameter int MAX_AREAS = 128
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // APB slave
  input wire dsb_pkg::dsb_apb_req_type i_apb,
  output dsb_pkg::dsb_apb_rsp_type o_apb,
  // Master side events
  input wire logic i_diag_req,
  input wire logic i_int_ack,
  // Response stream
  output dsb_pkg::dsb_tx_type o_tx,
  input wire logic i_tx_ready,
  // Status
  output logic o_int_pending
);
  import dsb_pkg::*;

  // ==========================================================================
  // Registers
  logic [31:0] ctrl_reg;
  logic [15:0] ident_reg;
  logic [7:0] areas_reg;
  logic [31:0] area_diag_reg;
  logic [7:0] int_slot_reg;
  logic [1:0] int_spec_reg;
  logic int_addack_reg;
  logic [31:0] int_data_reg;
  logic int_pend_reg;
  logic [4:0] seq_reg;
  logic [7:0] ack_cnt_reg;
  dsb_state_type state_reg;
  logic [6:0] idx_reg;
  logic [6:0] len_reg;
  logic [7:0] tx_data_reg;
  logic tx_valid_reg;
  logic tx_last_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic wr_en;
  logic raise;
  logic [6:0] idb_len;
  logic [6:0] mod_len;
  logic [6:0] tot_len;
  logic [7:0] byte_next;
  logic [7:0] n_areas;
  logic int_take;
  logic start;
  logic load;
  logic advance;
  logic finish;
  logic fetch;

  // Clamps the area count to at least one and at most the parameter
  function automatic logic [7:0] clamp_areas(input logic [7:0] n);
    logic [7:0] r;
    r = n;
    if (r == 8'h00) begin
      r = 8'h01;
    end
    if (32'(r) > MAX_AREAS) begin
      r = 8'(MAX_AREAS);
    end
    return r;
  endfunction

  // Block length from area count: header bytes plus ceil(n/per) data bytes, clamped to lo..hi
  function automatic logic [6:0] blk_len(input logic [7:0] n, input logic [6:0] hdr, input int shift,
                                         input logic [6:0] lo, input logic [6:0] hi);
    logic [8:0] d;
    logic [6:0] r;
    d = (9'(n) + 9'((1 << shift) - 1)) >> shift;
    r = hdr + d[6:0];
    if (r < lo) begin
      r = lo;
    end
    if (r > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Diagnostic flag of one transfer area; areas 32 and above report none
  function automatic logic area_bit(input logic [31:0] map, input logic [7:0] a);
    return (a < 8'h20) ? map[a[4:0]] : 1'b0;
  endfunction

  // Register write strobe for one offset
  function automatic logic hit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
    return en && (addr == ofs);
  endfunction

  assign n_areas = clamp_areas(areas_reg);
  assign idb_len = blk_len(n_areas, 7'h01, 3, DSB_IDB_MIN, DSB_IDB_MAX);
  assign mod_len = blk_len(n_areas, 7'h04, 2, DSB_MOD_MIN, DSB_MOD_MAX);
  assign tot_len = DSB_STD_LEN + idb_len + mod_len + (int_pend_reg ? DSB_INT_LEN : 7'h00);

  // ==========================================================================
  // APB slave, zero wait states
  assign addr_ok = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr <= DSB_OFS_STATUS);
  assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite && addr_ok;
  assign raise = hit(wr_en, i_apb.paddr, DSB_OFS_INT_CFG) && i_apb.pwdata[DSB_INT_RAISE];

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (i_apb.paddr)
      DSB_OFS_CTRL: rdata_next = ctrl_reg;
      DSB_OFS_IDENT: rdata_next = {16'h0000, ident_reg};
      DSB_OFS_AREAS: rdata_next = {24'h00_0000, areas_reg};
      DSB_OFS_AREA_DIAG: rdata_next = area_diag_reg;
      DSB_OFS_INT_CFG: rdata_next = {21'h00_0000, int_addack_reg, int_spec_reg, int_slot_reg};
      DSB_OFS_INT_DATA: rdata_next = int_data_reg;
      DSB_OFS_STATUS: rdata_next = {16'h0000, ack_cnt_reg, 1'b0, seq_reg, (state_reg == DSB_SEND), int_pend_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  assign o_apb.prdata = (i_apb.psel && !i_apb.pwrite) ? rdata_next : 32'h0000_0000;
  assign o_apb.pready = 1'b1;
  assign o_apb.pslverr = i_apb.psel && i_apb.penable && !addr_ok;

  // Writes to STATUS are dropped; INT_CFG fields load with a taken raise
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= DSB_RST_CTRL;
    end else if (hit(wr_en, i_apb.paddr, DSB_OFS_CTRL)) begin
      ctrl_reg <= {8'h00, i_apb.pwdata[23:16], 6'h00, i_apb.pwdata[9:0]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ident_reg <= DSB_RST_IDENT;
    end else if (hit(wr_en, i_apb.paddr, DSB_OFS_IDENT)) begin
      ident_reg <= i_apb.pwdata[15:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      areas_reg <= DSB_RST_AREAS;
    end else if (hit(wr_en, i_apb.paddr, DSB_OFS_AREAS)) begin
      areas_reg <= i_apb.pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      area_diag_reg <= 32'h0000_0000;
    end else if (hit(wr_en, i_apb.paddr, DSB_OFS_AREA_DIAG)) begin
      area_diag_reg <= i_apb.pwdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_data_reg <= 32'h0000_0000;
    end else if (hit(wr_en, i_apb.paddr, DSB_OFS_INT_DATA)) begin
      int_data_reg <= i_apb.pwdata;
    end
  end

  // ==========================================================================
  // Diagnostic interrupt: a new one is taken only when none is outstanding or the outstanding one is acknowledged in the same cycle
  assign int_take = raise && (!int_pend_reg || i_int_ack);

  // Set wins over an acknowledge in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_pend_reg <= 1'b0;
    end else if (int_take) begin
      int_pend_reg <= 1'b1;
    end else if (i_int_ack) begin
      int_pend_reg <= 1'b0;
    end
  end

  // Fields of a refused raise are dropped, keeping the pending report intact
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_slot_reg <= 8'h00;
      int_spec_reg <= 2'h0;
      int_addack_reg <= 1'b0;
      seq_reg <= 5'h00;
    end else if (int_take) begin
      int_slot_reg <= i_apb.pwdata[DSB_INT_SLOT_LSB +: 8];
      int_spec_reg <= i_apb.pwdata[DSB_INT_SPEC_LSB +: 2];
      int_addack_reg <= i_apb.pwdata[DSB_INT_ADDACK];
      seq_reg <= seq_reg + 5'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_cnt_reg <= 8'h00;
    end else if (i_int_ack && int_pend_reg) begin
      ack_cnt_reg <= ack_cnt_reg + 8'h01;
    end
  end

  assign o_int_pending = int_pend_reg;

  // ==========================================================================
  // Response byte for the current index
  always_comb begin
    logic [6:0] i;
    logic [7:0] a;
    logic [7:0] ss1;
    logic [7:0] ss2;
    logic [7:0] ss3;
    i = idx_reg;
    a = 8'h00;
    ss1 = 8'h00;
    ss2 = 8'h00;
    ss3 = 8'h00;
    byte_next = 8'h00;
    // Bits 7, 5, 4 and 0 belong to the master and go out as zero
    ss1[6] = ctrl_reg[DSB_CTRL_PRM_FAULT];
    ss1[3] = int_pend_reg || (area_diag_reg != 32'h0000_0000);
    ss1[2] = ctrl_reg[DSB_CTRL_CFG_FAULT];
    ss1[1] = ctrl_reg[DSB_CTRL_NOT_READY];
    ss2[5] = ctrl_reg[DSB_CTRL_SYNC];
    ss2[4] = ctrl_reg[DSB_CTRL_FREEZE];
    ss2[3] = ctrl_reg[DSB_CTRL_WDOG];
    ss2[2] = 1'b1;
    ss2[1] = ctrl_reg[DSB_CTRL_STATIC];
    ss2[0] = ctrl_reg[DSB_CTRL_PRM_REQ];
    ss3[7] = ctrl_reg[DSB_CTRL_OVERFLOW];
    if (i < DSB_STD_LEN) begin
      unique case (i[2:0])
        3'h0: byte_next = ss1;
        3'h1: byte_next = ss2;
        3'h2: byte_next = ss3;
        3'h3: byte_next = ctrl_reg[DSB_CTRL_CONFIGURED] ? ctrl_reg[DSB_CTRL_MADDR_LSB +: 8] : DSB_MADDR_NONE;
        3'h4: byte_next = ident_reg[7:0];
        default: byte_next = ident_reg[15:8];
      endcase
    end else if (i < DSB_STD_LEN + idb_len) begin
      i = i - DSB_STD_LEN;
      if (i == 7'h00) begin
        byte_next = {DSB_HDR_IDB, 6'(idb_len)};
      end else begin
        for (int b = 0; b < 8; b++) begin
          a = 8'({i - 7'h01, 3'h0} + b);
          byte_next[b] = (a < n_areas) && area_bit(area_diag_reg, a);
        end
      end
    end else if (i < DSB_STD_LEN + idb_len + mod_len) begin
      i = i - DSB_STD_LEN - idb_len;
      unique case (i)
        7'h00: byte_next = {DSB_HDR_DEV, 6'(mod_len)};
        7'h01: byte_next = {1'b1, DSB_STYPE_MOD_STAT};
        7'h02: byte_next = 8'h00;
        7'h03: byte_next = 8'h00;
        default: begin
          for (int s = 0; s < 4; s++) begin
            a = 8'({i - 7'h04, 2'h0} + s);
            byte_next[2 * s +: 2] = ((a < n_areas) && area_bit(area_diag_reg, a)) ? 2'h1 : 2'h0;
          end
        end
      endcase
    end else begin
      i = i - DSB_STD_LEN - idb_len - mod_len;
      unique case (i[2:0])
        3'h0: byte_next = {DSB_HDR_DEV, 6'(DSB_INT_LEN)};
        3'h1: byte_next = {1'b0, DSB_TYPE_DIAG_INT};
        3'h2: byte_next = int_slot_reg;
        3'h3: byte_next = {seq_reg, int_addack_reg, int_spec_reg};
        3'h4: byte_next = int_data_reg[7:0];
        3'h5: byte_next = int_data_reg[15:8];
        3'h6: byte_next = int_data_reg[23:16];
        default: byte_next = int_data_reg[31:24];
      endcase
    end
  end

  // ==========================================================================
  // Response sequencer
  // A byte moves on valid and ready at a rising edge
  assign start = (state_reg == DSB_IDLE) && i_diag_req;
  assign load = (state_reg == DSB_SEND) && !tx_valid_reg;
  assign advance = (state_reg == DSB_SEND) && tx_valid_reg && i_tx_ready && !tx_last_reg;
  assign finish = (state_reg == DSB_SEND) && tx_valid_reg && i_tx_ready && tx_last_reg;
  assign fetch = load || advance;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= DSB_IDLE;
    end else begin
      unique case (state_reg)
        DSB_IDLE: state_reg <= start ? DSB_SEND : DSB_IDLE;
        DSB_SEND: state_reg <= finish ? DSB_IDLE : DSB_SEND;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_reg <= 7'h00;
    end else if (start) begin
      idx_reg <= 7'h00;
    end else if (fetch) begin
      idx_reg <= idx_reg + 7'h01;
    end
  end

  // Length is frozen at the request; byte contents are read live
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      len_reg <= 7'h00;
    end else if (start) begin
      len_reg <= tot_len;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_valid_reg <= 1'b0;
    end else if (load) begin
      tx_valid_reg <= 1'b1;
    end else if (finish) begin
      tx_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_last_reg <= 1'b0;
    end else if (fetch) begin
      tx_last_reg <= (idx_reg == len_reg - 7'h01);
    end else if (finish) begin
      tx_last_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_data_reg <= 8'h00;
    end else if (fetch) begin
      tx_data_reg <= byte_next;
    end
  end

  assign o_tx.valid = tx_valid_reg;
  assign o_tx.last = tx_last_reg;
  assign o_tx.data = tx_data_reg;

endmodule

// >>> src/dsb_pkg.sv
// Purpose: Shared constants and types for the slave diagnostic response builder
// Assumes: APB register access, 32-bit data, byte-wide response stream
// Notes: Register offsets are byte addresses
package dsb_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] DSB_OFS_CTRL = 8'h00;
  localparam logic [7:0] DSB_OFS_IDENT = 8'h04;
  localparam logic [7:0] DSB_OFS_AREAS = 8'h08;
  localparam logic [7:0] DSB_OFS_AREA_DIAG = 8'h0C;
  localparam logic [7:0] DSB_OFS_INT_CFG = 8'h10;
  localparam logic [7:0] DSB_OFS_INT_DATA = 8'h14;
  localparam logic [7:0] DSB_OFS_STATUS = 8'h18;

  // CTRL field positions
  localparam int DSB_CTRL_PRM_FAULT = 0;
  localparam int DSB_CTRL_CFG_FAULT = 1;
  localparam int DSB_CTRL_NOT_READY = 2;
  localparam int DSB_CTRL_SYNC = 3;
  localparam int DSB_CTRL_FREEZE = 4;
  localparam int DSB_CTRL_WDOG = 5;
  localparam int DSB_CTRL_STATIC = 6;
  localparam int DSB_CTRL_PRM_REQ = 7;
  localparam int DSB_CTRL_OVERFLOW = 8;
  localparam int DSB_CTRL_CONFIGURED = 9;
  localparam int DSB_CTRL_MADDR_LSB = 16;

  // INT_CFG field positions
  localparam int DSB_INT_SLOT_LSB = 0;
  localparam int DSB_INT_SPEC_LSB = 8;
  localparam int DSB_INT_ADDACK = 10;
  localparam int DSB_INT_RAISE = 31;

  // Reset values
  localparam logic [31:0] DSB_RST_CTRL = 32'h0000_0004;
  localparam logic [15:0] DSB_RST_IDENT = 16'h0000;
  localparam logic [7:0] DSB_RST_AREAS = 8'h01;

  // ==========================================================================
  // Response layout
  localparam logic [6:0] DSB_STD_LEN = 7'h06;
  localparam logic [6:0] DSB_IDB_MIN = 7'h02;
  localparam logic [6:0] DSB_IDB_MAX = 7'h11;
  localparam logic [6:0] DSB_MOD_MIN = 7'h05;
  localparam logic [6:0] DSB_MOD_MAX = 7'h23;
  localparam logic [6:0] DSB_INT_LEN = 7'h08;
  localparam logic [7:0] DSB_MADDR_NONE = 8'hFF;
  localparam logic [1:0] DSB_HDR_IDB = 2'h1;
  localparam logic [1:0] DSB_HDR_DEV = 2'h0;
  localparam logic [6:0] DSB_TYPE_DIAG_INT = 7'h01;
  localparam logic [6:0] DSB_STYPE_MOD_STAT = 7'h02;

  // ==========================================================================
  // Types
  typedef enum logic {
    DSB_IDLE = 1'b0,
    DSB_SEND = 1'b1
  } dsb_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dsb_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsb_apb_rsp_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } dsb_tx_type;

endpackage

// >>> tb/dsb_diag_builder_bench.sv
// Purpose: Self-checking bench for the diagnostic builder
// Assumes: Zero wait APB, master model drains the stream
// Notes: Expected bytes are worked out by hand per scenario
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, (e), (a)); end end
module dsb_diag_builder_bench;
  import dsb_pkg::*;
  logic i_clk_sys, i_rst_b, i_diag_req, slow, ack_en, tx_ready, int_ack, pending;
  dsb_apb_req_type apb_req;
  dsb_apb_rsp_type apb_rsp;
  dsb_tx_type tx;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  dsb_diag_builder #(.MAX_AREAS(128)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_apb(apb_req),
    .o_apb(apb_rsp), .i_diag_req(i_diag_req), .i_int_ack(int_ack), .o_tx(tx), .i_tx_ready(tx_ready),
    .o_int_pending(pending));
  dsb_master_model i_mm (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tx(tx), .i_pending(pending),
    .o_ready(tx_ready), .o_ack(int_ack), .i_slow(slow), .i_ack_en(ack_en));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task final_report;
    $display("failures %0d checks %0d", failures, n_checks);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report;
    end
  end
  // ==========================================================================
  // Bus and stream tasks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge i_clk_sys); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task resp(input int n);
    int k;
    i_mm.rx.delete();
    @(posedge i_clk_sys);
    i_diag_req <= 1'b1;
    @(posedge i_clk_sys);
    i_diag_req <= 1'b0;
    k = 0;
    do begin @(posedge i_clk_sys); k++; end while (!(tx.valid && tx.last && tx_ready) && k < 1000);
    repeat (3) @(posedge i_clk_sys);
    `CHK("length", n, i_mm.rx.size())
  endtask
  // ==========================================================================
  // Scenarios
  task t_regs;
    apb(1'b0, DSB_OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0000_0004, rd)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, DSB_OFS_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, DSB_OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
  endtask
  task t_std;
    logic [31:0] c[2];
    logic [47:0] e[2];
    c = '{32'h002A_03FF, 32'h0};
    e = '{48'h463F_802A_EFBE, 48'h0004_00FF_EFBE};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, DSB_OFS_CTRL, c[i]);
      apb(1'b1, DSB_OFS_IDENT, 32'h0000_BEEF);
      resp(13);
      for (int j = 0; j < 6; j++) `CHK("std byte", e[i][47-8*j -: 8], i_mm.rx[j])
      `CHK("mod hdr", 8'h05, i_mm.rx[8])
      `CHK("variant", 8'h82, i_mm.rx[9])
    end
  endtask
  task t_big;
    apb(1'b1, DSB_OFS_AREAS, 32'h0000_00C8);
    apb(1'b1, DSB_OFS_AREA_DIAG, 32'h0000_0001);
    slow <= 1'b1;
    resp(58);
    `CHK("ext diag", 1'b1, i_mm.rx[0][3])
    `CHK("idb hdr", 8'h51, i_mm.rx[6])
    `CHK("idb map", 8'h01, i_mm.rx[7])
    `CHK("mod hdr", 8'h23, i_mm.rx[23])
    `CHK("mod area", 8'h01, i_mm.rx[27])
    slow <= 1'b0;
    apb(1'b1, DSB_OFS_AREAS, 32'h0000_0001);
    apb(1'b1, DSB_OFS_AREA_DIAG, 32'h0);
  endtask
  task t_int;
    logic [63:0] ei;
    ei = 64'h0801_030D_1122_3344;
    apb(1'b1, DSB_OFS_INT_DATA, 32'h4433_2211);
    apb(1'b1, DSB_OFS_INT_CFG, 32'h8000_0503);
    @(posedge i_clk_sys);
    `CHK("pending", 1'b1, pending)
    apb(1'b1, DSB_OFS_INT_CFG, 32'h8000_0007);
    resp(21);
    for (int j = 0; j < 8; j++) `CHK("int byte", ei[63-8*j -: 8], i_mm.rx[13+j])
    `CHK("ext diag", 1'b1, i_mm.rx[0][3])
    `CHK("held", 1'b1, pending)
    ack_en <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    ack_en <= 1'b0;
    `CHK("acked", 1'b0, pending)
    apb(1'b0, DSB_OFS_STATUS, 32'h0);
    `CHK("ack count", 8'h01, rd[15:8])
    resp(13);
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_diag_req = 1'b0;
    slow = 1'b0;
    ack_en = 1'b0;
    apb_req = '0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_regs;
    t_std;
    t_big;
    t_int;
    final_report;
  end
endmodule
bind dsb_diag_builder dsb_diag_builder_props i_props (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_apb(i_apb),
  .o_apb(o_apb), .i_diag_req(i_diag_req), .i_int_ack(i_int_ack), .o_tx(o_tx), .i_tx_ready(i_tx_ready),
  .o_int_pending(o_int_pending));

// >>> tb/dsb_diag_builder_props.sv
// Purpose: Concurrent checks on the diagnostic builder ports
// Assumes: One clock, reset low asynchronous
// Notes: Bound to the builder from the bench
`timescale 1ns/10ps
module dsb_diag_builder_props (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Bus and events
  input wire dsb_pkg::dsb_apb_req_type i_apb,
  input wire dsb_pkg::dsb_apb_rsp_type o_apb,
  input wire logic i_diag_req,
  input wire logic i_int_ack,
  // Stream and status
  input wire dsb_pkg::dsb_tx_type o_tx,
  input wire logic i_tx_ready,
  input wire logic o_int_pending
);
  import dsb_pkg::*;
  logic [6:0] idx_reg;
  logic [1:0] busy_reg;
  logic take;
  logic raise;
  assign take = o_tx.valid && i_tx_ready;
  assign raise = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == DSB_OFS_INT_CFG
    && i_apb.pwdata[DSB_INT_RAISE];
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) idx_reg <= 7'h00;
    else if (take) idx_reg <= o_tx.last ? 7'h00 : idx_reg + 7'h01;
  end
  // Busy from an accepted request until two cycles after the final byte
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) busy_reg <= 2'h0;
    else if (i_diag_req && busy_reg == 2'h0) busy_reg <= 2'h3;
    else if (take && o_tx.last) busy_reg <= 2'h2;
    else if (busy_reg != 2'h3 && busy_reg != 2'h0) busy_reg <= busy_reg - 2'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_first;
    !o_tx.valid ##1 (o_tx.valid && idx_reg == 7'h00);
  endsequence
  property p_start; i_diag_req && busy_reg == 2'h0 |=> s_first; endproperty
  a_start: assert property (p_start) else $error("response start late");
  property p_ss1; o_tx.valid && idx_reg == 7'h00 |-> (o_tx.data & 8'hB1) == 8'h00; endproperty
  a_ss1: assert property (p_ss1) else $error("status one owned bits set");
  property p_ss2; o_tx.valid && idx_reg == 7'h01 |-> o_tx.data[2] && o_tx.data[7:6] == 2'h0; endproperty
  a_ss2: assert property (p_ss2) else $error("status two fixed bits wrong");
  property p_ss3; o_tx.valid && idx_reg == 7'h02 |-> o_tx.data[6:0] == 7'h00; endproperty
  a_ss3: assert property (p_ss3) else $error("status three reserved bits set");
  property p_hold; o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data) && $stable(o_tx.last); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_len; take && o_tx.last |-> idx_reg >= 7'h0C && idx_reg <= 7'h41; endproperty
  a_len: assert property (p_len) else $error("response length out of range");
  property p_keep; o_int_pending && !i_int_ack |=> o_int_pending; endproperty
  a_keep: assert property (p_keep) else $error("interrupt dropped without ack");
  property p_ack; o_int_pending && i_int_ack && !raise |=> !o_int_pending; endproperty
  a_ack: assert property (p_ack) else $error("interrupt kept after ack");
  property p_raise; !o_int_pending && raise |=> o_int_pending; endproperty
  a_raise: assert property (p_raise) else $error("interrupt not raised");
endmodule

// >>> tb/dsb_master_model.sv
// Purpose: Fieldbus master stand-in that drains the diagnostic stream
// Assumes: One clock shared with the builder
// Notes: Slow mode takes a byte only every other cycle
`timescale 1ns/10ps
module dsb_master_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Builder side
  input wire dsb_pkg::dsb_tx_type i_tx,
  input wire logic i_pending,
  output logic o_ready,
  output logic o_ack,
  // Bench control
  input wire logic i_slow,
  input wire logic i_ack_en
);
  import dsb_pkg::*;
  logic [7:0] rx[$];
  logic tog_reg;
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
      o_ack <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      tog_reg <= ~tog_reg;
      o_ready <= !i_slow || tog_reg;
      if (i_tx.valid && o_ready) rx.push_back(i_tx.data);
      o_ack <= i_ack_en && i_pending && !o_ack;
    end
  end
endmodule
